// file: lsrc_asserts.sv
// port-level assertions for the lane switch
`timescale 1ns/100ps
module lsrc_asserts
    import lsrc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // serial and detector inputs
    input wire logic scl,
    input wire logic sda_oe,
    input wire logic [1:0] los_a,
    // outputs watched
    input wire logic [3:0] out_a_src,
    input wire logic [3:0] out_b_src,
    input wire logic [3:0] out_c_src,
    input wire logic [1:0] tx_on_a,
    input wire logic [1:0] tx_on_c,
    input wire logic [1:0] rx_on_b,
    input wire logic [7:0] eq_a
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    sequence c1_from_lost_a;
        out_c_src[3:2] == LSRC_SRC_A && $past(los_a[1]);
    endsequence
    a_idle_tx_off: assert property (out_a_src[1:0] == LSRC_SRC_IDLE |-> !tx_on_a[0])
        else $error("idle lane transmitting");
    a_los_squelch: assert property (c1_from_lost_a |-> !tx_on_c[1])
        else $error("lost input not squelched");
    a_a_never_b: assert property (out_a_src[1:0] != LSRC_SRC_B)
        else $error("output a fed from b");
    // c carries data once reset has settled
    a_c_never_idle: assert property (!$past(srst) && !$past(srst, 2) |-> out_c_src[1:0] != LSRC_SRC_IDLE)
        else $error("output c idle");
    a_loop_lanes: assert property (out_b_src[1:0] == LSRC_SRC_B |-> out_b_src[3:2] == LSRC_SRC_B)
        else $error("loopback not on both lanes");
    a_rx_demand: assert property (rx_on_b[0] |-> out_b_src[1:0] == LSRC_SRC_B || out_c_src[1:0] == LSRC_SRC_B)
        else $error("unused receiver on");
    a_eq_range: assert property (eq_a[3:0] <= EQ_MAX_CODE && eq_a[7:4] <= EQ_MAX_CODE)
        else $error("equalizer code out of range");
    a_ack_on_low: assert property ($rose(sda_oe) |-> !scl)
        else $error("data driven while clock high");
endmodule // lsrc_asserts

// file: lsrc_i2c_host.sv
// serial bus master model for register access
`timescale 1ns/100ps
module lsrc_i2c_host #(parameter logic [6:0] DEV_ADDR = 7'h55) (
    // clock
    input wire logic clock,
    // serial pins
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // each level held five clocks
    task automatic step(input logic c, input logic d);
        @(posedge clock);
        scl <= c;
        sda_low <= !d;
        repeat (4) @(posedge clock);
    endtask
    task automatic xbyte(input logic [7:0] d, output logic [7:0] q, inout logic nak);
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, (i == 0) ? 1'b1 : d[i-1]);
            step(1'b1, (i == 0) ? 1'b1 : d[i-1]);
            if (i == 0) nak |= sda;
            else q[i-1] = sda;
        end
    endtask
    task automatic start();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic nak);
        logic [7:0] q;
        nak = 1'b0;
        start();
        xbyte({DEV_ADDR, 1'b0}, q, nak);
        xbyte(ptr, q, nak);
        xbyte(d, q, nak);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    task automatic rd(input logic [7:0] ptr, output logic [7:0] q, output logic nak);
        logic junk;
        nak = 1'b0;
        junk = 1'b0;
        start();
        xbyte({DEV_ADDR, 1'b0}, q, nak);
        xbyte(ptr, q, nak);
        start();
        xbyte({DEV_ADDR, 1'b1}, q, nak);
        // ones let the slave drive; last bit nacks
        xbyte(8'hff, q, junk);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
endmodule // lsrc_i2c_host

// file: lsrc_i2c_slave.sv
// serial register slave: pointer byte, then data bytes with auto-increment
`timescale 1ns/100ps
module lsrc_i2c_slave
    import lsrc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // serial pins
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_oe,
    input wire logic [2:0] addr_pins,
    // register port
    output logic [7:0] reg_addr,
    output logic reg_wr_stb,
    output logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data
);

    typedef enum {ST_IDLE, ST_ADDR, ST_AACK, ST_WBYTE, ST_WACK, ST_RBYTE, ST_RACK} lsrc_i2c_st_t;

    lsrc_i2c_st_t state_r;
    logic scl_r, sda_r;
    logic [7:0] shift_r;
    logic [2:0] cnt_r;
    logic full_r, first_r, rw_r, acked_r;
    logic start_c, stop_c, rise_c, fall_c;

    assign start_c = scl & scl_r & sda_r & ~sda_i;
    assign stop_c = scl & scl_r & ~sda_r & sda_i;
    assign rise_c = scl & ~scl_r;
    assign fall_c = ~scl & scl_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
        end else begin
            scl_r <= scl;
            sda_r <= sda_i;
        end
    end

    always_ff @(posedge clock) begin
        reg_wr_stb <= 1'b0;
        if (srst) begin
            state_r <= ST_IDLE;
            shift_r <= 8'h00;
            cnt_r <= 3'h0;
            full_r <= 1'b0;
            first_r <= 1'b1;
            rw_r <= 1'b0;
            acked_r <= 1'b0;
            sda_oe <= 1'b0;
            reg_addr <= 8'h00;
            reg_wr_data <= 8'h00;
        end else if (start_c) begin
            state_r <= ST_ADDR;
            cnt_r <= 3'h0;
            full_r <= 1'b0;
            first_r <= 1'b1;
            sda_oe <= 1'b0;
        end else if (stop_c) begin
            state_r <= ST_IDLE;
            sda_oe <= 1'b0;
        end else if (rise_c) begin
            cnt_r <= cnt_r + 3'h1;
            full_r <= (cnt_r == 3'h7);
            if (state_r == ST_ADDR || state_r == ST_WBYTE) begin
                shift_r <= {shift_r[6:0], sda_i};
            end
            if (state_r == ST_RACK) begin
                acked_r <= ~sda_i;
            end
        end else if (fall_c) begin
            unique case (state_r)
                ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                ST_ADDR: begin
                    if (full_r) begin
                        full_r <= 1'b0;
                        if (shift_r[7:1] == {I2C_ADDR_HIGH, addr_pins}) begin
                            state_r <= ST_AACK;
                            rw_r <= shift_r[0];
                            sda_oe <= 1'b1;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_AACK, ST_RACK: begin
                    cnt_r <= 3'h0;
                    if (rw_r && (state_r == ST_AACK || acked_r)) begin
                        // msb out now, the rest on later falls
                        state_r <= ST_RBYTE;
                        sda_oe <= ~reg_rd_data[7];
                        shift_r <= {reg_rd_data[6:0], 1'b0};
                        reg_addr <= reg_addr + 8'h01;
                    end else if (!rw_r) begin
                        state_r <= ST_WBYTE;
                        sda_oe <= 1'b0;
                    end else begin
                        state_r <= ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                end
                ST_WBYTE: begin
                    if (full_r) begin
                        full_r <= 1'b0;
                        state_r <= ST_WACK;
                        sda_oe <= 1'b1;
                        if (first_r) begin
                            reg_addr <= shift_r;
                        end else begin
                            reg_wr_stb <= 1'b1;
                            reg_wr_data <= shift_r;
                        end
                    end
                end
                ST_WACK: begin
                    state_r <= ST_WBYTE;
                    sda_oe <= 1'b0;
                    cnt_r <= 3'h0;
                    reg_addr <= first_r ? reg_addr : reg_addr + 8'h01;
                    first_r <= 1'b0;
                end
                ST_RBYTE: begin
                    if (full_r) begin
                        full_r <= 1'b0;
                        state_r <= ST_RACK;
                        sda_oe <= 1'b0;
                    end else begin
                        sda_oe <= ~shift_r[7];
                        shift_r <= {shift_r[6:0], 1'b0};
                    end
                end
            endcase
        end
    end

endmodule // lsrc_i2c_slave

// file: lsrc_pkg.sv
// shared constants for the lane switch route control block
package lsrc_pkg;

    // register offsets
    localparam logic [7:0] REG_SWITCH_CONTROL = 8'h01;
    localparam logic [7:0] REG_CONTROL_MODE = 8'h0f;
    localparam logic [7:0] REG_RX_LANE_OFF [3] = '{8'h40, 8'h80, 8'hc0};
    localparam logic [7:0] REG_EQ_ALL_LANES [3] = '{8'h41, 8'h81, 8'hc1};
    localparam logic [7:0] REG_EQ_PER_LANE [3] = '{8'h42, 8'h82, 8'hc2};
    localparam logic [7:0] REG_PN_SWAP [3] = '{8'h44, 8'h84, 8'hc4};
    localparam logic [7:0] REG_TX_LANE_OFF [3] = '{8'h48, 8'h88, 8'hc8};

    // switch control fields
    localparam int SWC_SEL_LSB = 0;
    localparam int SWC_DUAL_CAST_BIT = 2;
    localparam int SWC_LOOP_LSB = 4;

    // per-lane equalizer fields, lane 0 low nibble, lane 1 high nibble
    localparam int EQ_W = 4;
    localparam logic [3:0] EQ_MAX_CODE = 4'h9;
    localparam logic [3:0] EQ_PIN_HIGH_CODE = 4'h4;
    localparam logic [3:0] EQ_PIN_LOW_CODE = 4'h0;

    // reset values
    localparam logic [7:0] SWITCH_CONTROL_RST = 8'h00;
    localparam logic [1:0] CONTROL_MODE_RST = 2'h0;
    localparam logic [1:0] LANE_OFF_RST = 2'h0;
    localparam logic [3:0] EQ_RST = 4'h0;

    // serial slave address, upper bits fixed, lower bits from pins
    localparam logic [3:0] I2C_ADDR_HIGH = 4'ha;

    typedef enum logic [1:0] {
        LSRC_MODE_PIN = 2'b00,
        LSRC_MODE_RSVD = 2'b01,
        LSRC_MODE_MIXED = 2'b10,
        LSRC_MODE_SERIAL = 2'b11
    } lsrc_mode_t;

    // output lane source code
    typedef enum logic [1:0] {
        LSRC_SRC_IDLE = 2'b00,
        LSRC_SRC_A = 2'b01,
        LSRC_SRC_B = 2'b10,
        LSRC_SRC_C = 2'b11
    } lsrc_src_t;

endpackage

// file: lsrc_top.sv
// lane switch route control: register map, control source selection, routing and lane enables
// Operation
// - routing comes from control pins or register writes, per control mode
// - without loopback, output C lane takes input A when select 0, B when 1
// - unicast: input C goes to output A on select 0, output B on 1
// - dual-cast drives both outputs A and B from input C, loopback excepted
// - idle lane: transmitter current off, terminations pull both sides up
// - receivers whose data no output uses are switched off
// - per-port loopback overrides lane select and dual-cast for that port
// - in serial mode switch control bits 6:4 act as the loopback pins
// - looped port outputs its own input on both lanes, others keep routing
// - register equalizer codes 0 to 9 give 0 to 18 dB in 2 dB steps
// - equalizer pin low gives code 0, high gives code 4 (8 dB)
// - port-level equalizer write sets all lanes of that port, replacing per-lane values
// - one per-lane equalizer register per port sets each lane individually
// - receivers and transmitters turn on only when routing state needs them
// - receiver disable register bit per lane forces that receiver off
// - transmitter disable register bit per lane forces that transmitter off
// - loss of signal on a receiver squelches the transmitter carrying its data
// - per-receiver option inverts incoming differential polarity
// - mode field 00 pin, 10 mixed, 11 serial control
// - serial mode ignores every control pin except reset
// - disable registers: bit 1 lane 1, bit 0 lane 0, one means off
`timescale 1ns/100ps
module lsrc_top
    import lsrc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // serial register access pins
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [2:0] i2c_addr_pins,
    // switch control pins
    input wire logic [1:0] lane_sel,
    input wire logic dual_cast,
    input wire logic loop_port_a,
    input wire logic loop_port_b,
    input wire logic loop_port_c,
    // equalizer pins, one per port
    input wire logic eq_pin_a,
    input wire logic eq_pin_b,
    input wire logic eq_pin_c,
    // loss-of-signal detector flags, one per lane
    input wire logic [1:0] los_a,
    input wire logic [1:0] los_b,
    input wire logic [1:0] los_c,
    // output lane source, two bits per lane, lane 1 high
    output logic [3:0] out_a_src,
    output logic [3:0] out_b_src,
    output logic [3:0] out_c_src,
    // transmitter current enables
    output logic [1:0] tx_on_a,
    output logic [1:0] tx_on_b,
    output logic [1:0] tx_on_c,
    // receiver enables
    output logic [1:0] rx_on_a,
    output logic [1:0] rx_on_b,
    output logic [1:0] rx_on_c,
    // equalizer codes, lane 1 in the high nibble
    output logic [7:0] eq_a,
    output logic [7:0] eq_b,
    output logic [7:0] eq_c,
    // receiver polarity inversion
    output logic [1:0] pn_swap_a,
    output logic [1:0] pn_swap_b,
    output logic [1:0] pn_swap_c
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0] reg_addr;
    logic reg_wr_stb;
    logic [7:0] reg_wr_data;
    logic [7:0] reg_rd_data;

    logic [7:0] switch_control_r;
    lsrc_mode_t mode_r;
    logic [1:0] rx_lane_off_r [3];
    logic [1:0] tx_lane_off_r [3];
    logic [3:0] eq_all_lanes_r [3];
    logic [7:0] eq_per_lane_r [3];
    logic [1:0] pn_swap_r [3];

    logic pins_route;
    logic pins_eq;
    logic [1:0] sel_eff;
    logic dual_eff;
    logic [2:0] loop_eff;
    logic [1:0] los_in [3];
    logic [1:0] eq_pin_lane [3];
    logic [2:0] eq_pin_in;

    lsrc_src_t src_nxt [3][2];
    logic [1:0] tx_on_nxt [3];
    logic [1:0] rx_on_nxt [3];
    logic [7:0] eq_nxt [3];
    logic [1:0] pn_nxt [3];

    lsrc_src_t src_r [3][2];
    logic [1:0] tx_on_r [3];
    logic [1:0] rx_on_r [3];
    logic [7:0] eq_r [3];
    logic [1:0] pn_r [3];

    // writes above code 9 saturate rather than wrap to a weaker boost
    function automatic logic [3:0] eq_clamp(input logic [3:0] v);
        return (v > EQ_MAX_CODE) ? EQ_MAX_CODE : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // serial register access

    lsrc_i2c_slave u_i2c (
        .clock(clock),
        .srst(srst),
        .scl(scl),
        .sda_i(sda_i),
        .sda_oe(sda_oe),
        .addr_pins(i2c_addr_pins),
        .reg_addr(reg_addr),
        .reg_wr_stb(reg_wr_stb),
        .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data)
    );

    // open drain: only ever pulls low
    assign sda_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // global registers

    always_ff @(posedge clock) begin
        if (srst) begin
            mode_r <= lsrc_mode_t'(CONTROL_MODE_RST);
        end else if (reg_wr_stb && reg_addr == REG_CONTROL_MODE) begin
            mode_r <= lsrc_mode_t'(reg_wr_data[1:0]);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            switch_control_r <= SWITCH_CONTROL_RST;
        end else if (reg_wr_stb && reg_addr == REG_SWITCH_CONTROL) begin
            // bits 3 and 7 read zero
            switch_control_r <= {1'b0, reg_wr_data[6:4], 1'b0, reg_wr_data[2:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-port registers

    assign los_in[0] = los_a;
    assign los_in[1] = los_b;
    assign los_in[2] = los_c;
    assign eq_pin_in = {eq_pin_c, eq_pin_b, eq_pin_a};

    generate
        for (genvar p = 0; p < 3; p++) begin : g_port_regs
            always_ff @(posedge clock) begin
                if (srst) begin
                    rx_lane_off_r[p] <= LANE_OFF_RST;
                end else if (reg_wr_stb && reg_addr == REG_RX_LANE_OFF[p]) begin
                    rx_lane_off_r[p] <= reg_wr_data[1:0];
                end
            end

            always_ff @(posedge clock) begin
                if (srst) begin
                    tx_lane_off_r[p] <= LANE_OFF_RST;
                end else if (reg_wr_stb && reg_addr == REG_TX_LANE_OFF[p]) begin
                    tx_lane_off_r[p] <= reg_wr_data[1:0];
                end
            end

            always_ff @(posedge clock) begin
                if (srst) begin
                    pn_swap_r[p] <= LANE_OFF_RST;
                end else if (reg_wr_stb && reg_addr == REG_PN_SWAP[p]) begin
                    pn_swap_r[p] <= reg_wr_data[1:0];
                end
            end

            // a port-level write also lands in both lane fields
            always_ff @(posedge clock) begin
                if (srst) begin
                    eq_all_lanes_r[p] <= EQ_RST;
                    eq_per_lane_r[p] <= {EQ_RST, EQ_RST};
                end else if (reg_wr_stb && reg_addr == REG_EQ_ALL_LANES[p]) begin
                    eq_all_lanes_r[p] <= eq_clamp(reg_wr_data[3:0]);
                    eq_per_lane_r[p] <= {eq_clamp(reg_wr_data[3:0]), eq_clamp(reg_wr_data[3:0])};
                end else if (reg_wr_stb && reg_addr == REG_EQ_PER_LANE[p]) begin
                    eq_per_lane_r[p] <= {eq_clamp(reg_wr_data[7:4]), eq_clamp(reg_wr_data[3:0])};
                end
            end
        end
    endgenerate

    // read back; unmapped offsets read zero
    always_comb begin
        reg_rd_data = 8'h00;
        if (reg_addr == REG_CONTROL_MODE) begin
            reg_rd_data = {6'h00, mode_r};
        end
        if (reg_addr == REG_SWITCH_CONTROL) begin
            reg_rd_data = switch_control_r;
        end
        for (int p = 0; p < 3; p++) begin
            if (reg_addr == REG_RX_LANE_OFF[p]) begin
                reg_rd_data = {6'h00, rx_lane_off_r[p]};
            end
            if (reg_addr == REG_TX_LANE_OFF[p]) begin
                reg_rd_data = {6'h00, tx_lane_off_r[p]};
            end
            if (reg_addr == REG_PN_SWAP[p]) begin
                reg_rd_data = {6'h00, pn_swap_r[p]};
            end
            if (reg_addr == REG_EQ_ALL_LANES[p]) begin
                reg_rd_data = {4'h0, eq_all_lanes_r[p]};
            end
            if (reg_addr == REG_EQ_PER_LANE[p]) begin
                reg_rd_data = eq_per_lane_r[p];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control source selection

    // reserved mode code behaves as pin control
    assign pins_route = (mode_r != LSRC_MODE_SERIAL);
    assign pins_eq = (mode_r == LSRC_MODE_PIN) || (mode_r == LSRC_MODE_RSVD);

    always_comb begin
        if (pins_route) begin
            sel_eff = lane_sel;
            dual_eff = dual_cast;
            loop_eff = {loop_port_c, loop_port_b, loop_port_a};
        end else begin
            sel_eff = switch_control_r[SWC_SEL_LSB +: 2];
            dual_eff = switch_control_r[SWC_DUAL_CAST_BIT];
            loop_eff = switch_control_r[SWC_LOOP_LSB +: 3];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // routing decode per lane

    generate
        for (genvar l = 0; l < 2; l++) begin : g_lane
            always_comb begin
                // port A output: loopback first, then dual-cast or select 0 demux
                if (loop_eff[0]) begin
                    src_nxt[0][l] = LSRC_SRC_A;
                end else if (dual_eff || !sel_eff[l]) begin
                    src_nxt[0][l] = LSRC_SRC_C;
                end else begin
                    src_nxt[0][l] = LSRC_SRC_IDLE;
                end
                // port B output
                if (loop_eff[1]) begin
                    src_nxt[1][l] = LSRC_SRC_B;
                end else if (dual_eff || sel_eff[l]) begin
                    src_nxt[1][l] = LSRC_SRC_C;
                end else begin
                    src_nxt[1][l] = LSRC_SRC_IDLE;
                end
                // port C output: loopback first, else mux of A and B
                if (loop_eff[2]) begin
                    src_nxt[2][l] = LSRC_SRC_C;
                end else begin
                    src_nxt[2][l] = sel_eff[l] ? LSRC_SRC_B : LSRC_SRC_A;
                end
            end

            for (genvar p = 0; p < 3; p++) begin : g_port
                always_comb begin
                    // transmitter off when idle, disabled, or its source receiver lost signal
                    tx_on_nxt[p][l] = 1'b0;
                    unique case (src_nxt[p][l])
                        LSRC_SRC_IDLE: tx_on_nxt[p][l] = 1'b0;
                        LSRC_SRC_A: tx_on_nxt[p][l] = !los_in[0][l];
                        LSRC_SRC_B: tx_on_nxt[p][l] = !los_in[1][l];
                        LSRC_SRC_C: tx_on_nxt[p][l] = !los_in[2][l];
                    endcase
                    if (tx_lane_off_r[p][l]) begin
                        tx_on_nxt[p][l] = 1'b0;
                    end
                end

                // a receiver runs only while some output lane uses it
                assign rx_on_nxt[p][l] = !rx_lane_off_r[p][l] &&
                    (src_nxt[0][l] == lsrc_src_t'(p + 1) ||
                     src_nxt[1][l] == lsrc_src_t'(p + 1) ||
                     src_nxt[2][l] == lsrc_src_t'(p + 1));

                assign eq_pin_lane[p][l] = eq_pin_in[p];
            end
        end
    endgenerate

    generate
        for (genvar p = 0; p < 3; p++) begin : g_port_eq
            always_comb begin
                if (pins_eq) begin
                    eq_nxt[p][3:0] = eq_pin_lane[p][0] ? EQ_PIN_HIGH_CODE : EQ_PIN_LOW_CODE;
                    eq_nxt[p][7:4] = eq_pin_lane[p][1] ? EQ_PIN_HIGH_CODE : EQ_PIN_LOW_CODE;
                    pn_nxt[p] = 2'h0;
                end else begin
                    eq_nxt[p] = eq_per_lane_r[p];
                    pn_nxt[p] = pn_swap_r[p];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // output stage: one flop between decode and pins

    always_ff @(posedge clock) begin
        for (int p = 0; p < 3; p++) begin
            if (srst) begin
                src_r[p][0] <= LSRC_SRC_IDLE;
                src_r[p][1] <= LSRC_SRC_IDLE;
                tx_on_r[p] <= 2'h0;
                rx_on_r[p] <= 2'h0;
                eq_r[p] <= {EQ_RST, EQ_RST};
                pn_r[p] <= 2'h0;
            end else begin
                src_r[p][0] <= src_nxt[p][0];
                src_r[p][1] <= src_nxt[p][1];
                tx_on_r[p] <= tx_on_nxt[p];
                rx_on_r[p] <= rx_on_nxt[p];
                eq_r[p] <= eq_nxt[p];
                pn_r[p] <= pn_nxt[p];
            end
        end
    end

    assign out_a_src = {src_r[0][1], src_r[0][0]};
    assign out_b_src = {src_r[1][1], src_r[1][0]};
    assign out_c_src = {src_r[2][1], src_r[2][0]};
    assign tx_on_a = tx_on_r[0];
    assign tx_on_b = tx_on_r[1];
    assign tx_on_c = tx_on_r[2];
    assign rx_on_a = rx_on_r[0];
    assign rx_on_b = rx_on_r[1];
    assign rx_on_c = rx_on_r[2];
    assign eq_a = eq_r[0];
    assign eq_b = eq_r[1];
    assign eq_c = eq_r[2];
    assign pn_swap_a = pn_r[0];
    assign pn_swap_b = pn_r[1];
    assign pn_swap_c = pn_r[2];

endmodule // lsrc_top

// file: tb.sv
// testbench for the lane switch route control
`timescale 1ns/100ps
module tb;
    import lsrc_pkg::*;
    logic clock, srst, scl, sda_o, sda_oe, host_low, dual_cast, loop_port_a, loop_port_b, loop_port_c, nak;
    logic eq_pin_a, eq_pin_b, eq_pin_c;
    logic [2:0] i2c_addr_pins = 3'h5;
    logic [1:0] lane_sel, los_a, los_b, los_c, tx_on_a, tx_on_b, tx_on_c, rx_on_a, rx_on_b, rx_on_c;
    logic [1:0] pn_swap_a, pn_swap_b, pn_swap_c;
    logic [3:0] out_a_src, out_b_src, out_c_src;
    logic [7:0] eq_a, eq_b, eq_c, q;
    logic [5:0] pins;
    int error_cnt = 0;
    int n_checks = 0;
    // pulled-up open-drain data line
    wire logic sda_i = !(sda_oe | host_low);
    assign {loop_port_c, loop_port_b, loop_port_a, dual_cast, lane_sel} = pins;
    lsrc_top lsrc_top_i (.*);
    lsrc_i2c_host lsrc_i2c_host_i (.clock(clock), .sda(sda_i), .scl(scl), .sda_low(host_low));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [1:0] src_of(input int p, input logic [2:0] lp, input logic dual, s);
        case (p)
            0: return lp[0] ? LSRC_SRC_A : (dual || !s) ? LSRC_SRC_C : LSRC_SRC_IDLE;
            1: return lp[1] ? LSRC_SRC_B : (dual || s) ? LSRC_SRC_C : LSRC_SRC_IDLE;
            default: return lp[2] ? LSRC_SRC_C : s ? LSRC_SRC_B : LSRC_SRC_A;
        endcase
    endfunction
    task automatic chk_route(input logic [2:0] lp, input logic dual, input logic [1:0] sel, rxa_off, txc_off);
        logic [11:0] es;
        logic [5:0] et, er;
        logic [1:0] s;
        logic [3:0] used;
        #1;
        for (int l = 0; l < 2; l++) begin
            used = 4'h0;
            for (int p = 0; p < 3; p++) begin
                s = src_of(p, lp, dual, sel[l]);
                es[p*4+l*2 +: 2] = s;
                et[p*2+l] = (s != LSRC_SRC_IDLE) && !(p == 2 && txc_off[l]);
                used[s] = 1'b1;
            end
            for (int p = 0; p < 3; p++) er[p*2+l] = used[p+1] && !(p == 0 && rxa_off[l]);
        end
        check("src", {out_c_src, out_b_src, out_a_src}, es);
        check("tx_on", {tx_on_c, tx_on_b, tx_on_a}, et);
        check("rx_on", {rx_on_c, rx_on_b, rx_on_a}, er);
    endtask
    task automatic wrc(input logic [7:0] ptr, input logic [7:0] d);
        lsrc_i2c_host_i.wr(ptr, d, nak);
        check("ack", nak, 1'b0);
    endtask
    task automatic rdc(input logic [7:0] ptr, input logic [7:0] exp);
        lsrc_i2c_host_i.rd(ptr, q, nak);
        check("ack", nak, 1'b0);
        check("read", q, exp);
    endtask
    initial begin
        repeat (100000) @(posedge clock);
        error_cnt++;
        close_out();
    end
    initial begin
        srst = 1'b1;
        pins = 6'h00;
        {eq_pin_a, eq_pin_b, eq_pin_c, los_a, los_b, los_c} = 9'h000;
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        repeat (3) @(posedge clock);
        for (int v = 0; v < 64; v++) begin
            @(posedge clock);
            pins <= 6'(v);
            @(posedge clock);
            chk_route(3'(v >> 3), v[2], v[1:0], 2'b00, 2'b00);
        end
        $display("test pin routing done");
        @(posedge clock);
        eq_pin_a <= 1'b1;
        repeat (2) @(posedge clock);
        #1 check("eq_a", eq_a, 8'h44);
        check("eq_b", eq_b, 8'h00);
        $display("test equalizer pins done");
        wrc(REG_SWITCH_CONTROL, 8'h21);
        wrc(REG_RX_LANE_OFF[0], 8'h02);
        wrc(REG_TX_LANE_OFF[2], 8'h01);
        wrc(REG_CONTROL_MODE, 8'h03);
        chk_route(3'b010, 1'b0, 2'b01, 2'b10, 2'b01);
        @(posedge clock);
        los_a <= 2'b10;
        repeat (2) @(posedge clock);
        #1 check("tx_on_c", tx_on_c, 2'b00);
        @(posedge clock);
        los_a <= 2'b00;
        wrc(REG_EQ_PER_LANE[0], 8'h37);
        check("eq_a", eq_a, 8'h37);
        wrc(REG_EQ_ALL_LANES[0], 8'h05);
        check("eq_a", eq_a, 8'h55);
        rdc(REG_EQ_PER_LANE[0], 8'h55);
        wrc(REG_EQ_ALL_LANES[2], 8'h0c);
        check("eq_c", eq_c, 8'h99);
        wrc(REG_PN_SWAP[1], 8'h02);
        check("pn_swap", {pn_swap_c, pn_swap_b, pn_swap_a}, 6'h08);
        rdc(REG_SWITCH_CONTROL, 8'h21);
        rdc(8'h30, 8'h00);
        rdc(REG_CONTROL_MODE, 8'h03);
        $display("test serial mode done");
        wrc(REG_CONTROL_MODE, 8'h02);
        @(posedge clock);
        pins <= 6'b001000;
        @(posedge clock);
        chk_route(3'b001, 1'b0, 2'b00, 2'b10, 2'b01);
        check("eq_a", eq_a, 8'h55);
        $display("test mixed mode done");
        close_out();
    end
endmodule // tb
bind lsrc_top lsrc_asserts lsrc_asserts_i (.*);
